//--- src/pwm_dac_consts.svh
// constants for the pwm dac word access port
`ifndef PWM_DAC_CONSTS_SVH
`define PWM_DAC_CONSTS_SVH
`define SEL_COUNTER        2'h0
`define SEL_DUTY_A         2'h1
`define SEL_DUTY_B         2'h2
`define SEL_CONTROL        2'h3
`define CTRL_INVERT_BIT    1
`define CTRL_RES_BIT       0
`define WORD_RESET         16'h0000
`define BYTE_RESET         8'h00
`define CLK_PERIOD_NS      40
`endif

//--- src/pwm_dac_pkg.sv
// types for the pwm dac word access port
package pwm_dac_pkg;
   typedef logic [15:0] word_t;
   typedef logic [7:0]  byte_t;
endpackage

//--- src/byte_bus_if.sv
// byte access request carried between the port and its latch
`timescale 1ns/1ns
`default_nettype none
interface byte_bus_if;
   logic       wr;
   logic       rd;
   logic       upper;
   logic [7:0] wdata;
   logic [7:0] live_low;
   logic [7:0] held;
   modport port  (output wr, output rd, output upper, output wdata, output live_low, input held);
   modport latch (input wr, input rd, input upper, input wdata, input live_low, output held);
endinterface
`default_nettype wire

//--- src/holding_latch.sv
// shared 8-bit holding latch for split word access
`timescale 1ns/1ns
`default_nettype none
`include "pwm_dac_consts.svh"
module holding_latch
   import pwm_dac_pkg::*;
(
   input  wire logic     clk_i,
   input  wire logic     arst_n_i,
   byte_bus_if.latch     bus
);
   byte_t held;
   wire   load_wr = bus.wr & bus.upper;
   wire   load_rd = bus.rd & bus.upper;
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         held <= `BYTE_RESET;
      else if (load_wr)
         held <= bus.wdata;
      else if (load_rd)
         held <= bus.live_low;
   end
   assign bus.held = held;
endmodule
`default_nettype wire

//--- src/pwm_dac_word_access_port.sv
// bus access logic for the two channel pwm dac word registers
//
// Summary of operation
// - invert bit resets 0, flips pwm output
// - resolution bit: step one or two clocks
// - three 16-bit registers via 8-bit latch
// - upper byte write only fills latch
// - lower write loads latch plus byte
// - upper read returns high, latches low
// - lower read returns latched byte
// - duty words only held, driven on DUTY_DATA_A_O and DUTY_DATA_B_O
`timescale 1ns/1ns
`default_nettype none
`include "pwm_dac_consts.svh"
module pwm_dac_word_access_port
   import pwm_dac_pkg::*;
(
   input  wire logic       CLK_SYS_I,
   input  wire logic       ARST_N_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   input  wire logic [1:0] SEL_I,
   input  wire logic       UPPER_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       COUNT_LOAD_I,
   input  wire logic       PWM_RAW_I,
   output logic      [7:0] RDATA_O,
   output logic     [15:0] PWM_STEP_COUNTER_O,
   output logic     [15:0] DUTY_DATA_A_O,
   output logic     [15:0] DUTY_DATA_B_O,
   output logic            OUTPUT_INVERT_SEL_O,
   output logic            RESOLUTION_SEL_O,
   output logic            STEP_TICK_O,
   output logic            PWM_O
);
   word_t      pwm_step_counter;
   word_t      duty_data_a;
   word_t      duty_data_b;
   logic       output_invert_sel;
   logic       resolution_sel;
   logic       half_step;
   byte_bus_if lb();

   // byte half of a word register
   function automatic byte_t pick(input word_t w, input logic up);
      if (up)
         pick = w[15:8];
      else
         pick = w[7:0];
   endfunction

   // select code match
   function automatic logic is_sel(input logic [1:0] sel, input logic [1:0] code);
      is_sel = (sel == code);
   endfunction

   // word register addressed by a select code
   function automatic word_t word_of(input logic [1:0] sel, input word_t cnt, input word_t a, input word_t b);
      unique case (sel)
         `SEL_DUTY_A:
            word_of = a;
         `SEL_DUTY_B:
            word_of = b;
         `SEL_COUNTER, `SEL_CONTROL:
            word_of = cnt;
      endcase
   endfunction

   // control byte as seen on a read
   function automatic byte_t ctrl_byte(input logic inv, input logic res);
      ctrl_byte                   = `BYTE_RESET;
      ctrl_byte[`CTRL_INVERT_BIT] = inv;
      ctrl_byte[`CTRL_RES_BIT]    = res;
   endfunction

   // counter advance, wraps at the top
   function automatic word_t bump(input word_t w);
      bump = 16'(w + 16'h0001);
   endfunction

   // register selection
   wire        sel_cnt    = is_sel(SEL_I, `SEL_COUNTER);
   wire        sel_a      = is_sel(SEL_I, `SEL_DUTY_A);
   wire        sel_b      = is_sel(SEL_I, `SEL_DUTY_B);
   wire        sel_ctrl   = is_sel(SEL_I, `SEL_CONTROL);
   wire        word_sel   = ~sel_ctrl;
   wire word_t target     = word_of(SEL_I, pwm_step_counter, duty_data_a, duty_data_b);

   // write decoding
   wire        wr_word    = WR_I & word_sel;
   wire        low_wr     = wr_word & ~UPPER_I;
   wire        load_cnt   = low_wr & sel_cnt;
   wire        load_a     = low_wr & sel_a;
   wire        load_b     = low_wr & sel_b;
   wire        load_ctrl  = WR_I & sel_ctrl;
   wire        next_inv   = WDATA_I[`CTRL_INVERT_BIT];
   wire        next_res   = WDATA_I[`CTRL_RES_BIT];
   wire word_t joined     = {lb.held, WDATA_I};

   // read selection
   wire        rd_word    = RD_I & word_sel;
   wire byte_t upper_rd   = pick(target, 1'b1);
   wire byte_t live_low   = pick(target, 1'b0);
   wire byte_t word_rd    = UPPER_I ? upper_rd : lb.held;
   wire byte_t ctrl_rd    = ctrl_byte(output_invert_sel, resolution_sel);
   wire byte_t next_rdata = RD_I ? (sel_ctrl ? ctrl_rd : word_rd) : `BYTE_RESET;

   // step pacing and output phase
   wire        step       = ~resolution_sel | half_step;
   wire        next_half  = resolution_sel & ~half_step;
   wire word_t next_count = bump(pwm_step_counter);
   wire        next_pwm   = PWM_RAW_I ^ output_invert_sel;

   // request to the shared latch
   assign lb.wr       = wr_word;
   assign lb.rd       = rd_word;
   assign lb.upper    = UPPER_I;
   assign lb.wdata    = WDATA_I;
   assign lb.live_low = live_low;

   holding_latch u_latch
   (
      .clk_i    (CLK_SYS_I),
      .arst_n_i (ARST_N_I),
      .bus      (lb)
   );

   // word registers
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         pwm_step_counter <= `WORD_RESET;
      else if (load_cnt)
         pwm_step_counter <= joined;
      else if (COUNT_LOAD_I)
         pwm_step_counter <= `WORD_RESET;
      else if (step)
         pwm_step_counter <= next_count;
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         duty_data_a <= `WORD_RESET;
      else if (load_a)
         duty_data_a <= joined;
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         duty_data_b <= `WORD_RESET;
      else if (load_b)
         duty_data_b <= joined;
   end

   // control bits
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         output_invert_sel <= 1'b0;
      else if (load_ctrl)
         output_invert_sel <= next_inv;
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         resolution_sel <= 1'b0;
      else if (load_ctrl)
         resolution_sel <= next_res;
   end

   // pacing and output
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         half_step <= 1'b0;
      else
         half_step <= next_half;
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         STEP_TICK_O <= 1'b0;
      else
         STEP_TICK_O <= step;
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         PWM_O <= 1'b0;
      else
         PWM_O <= next_pwm;
   end

   // read data
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         RDATA_O <= `BYTE_RESET;
      else
         RDATA_O <= next_rdata;
   end

   // outputs
   assign PWM_STEP_COUNTER_O  = pwm_step_counter;
   assign DUTY_DATA_A_O       = duty_data_a;
   assign DUTY_DATA_B_O       = duty_data_b;
   assign OUTPUT_INVERT_SEL_O = output_invert_sel;
   assign RESOLUTION_SEL_O    = resolution_sel;
endmodule
`default_nettype wire

//--- tb/pwm_dac_props_properties.sv
// concurrent checks on the pwm dac word access port
`timescale 1ns/1ns
`default_nettype none
module pwm_dac_props (
   input wire logic        CLK_SYS_I, ARST_N_I, WR_I, RD_I, UPPER_I, PWM_RAW_I, PWM_O, STEP_TICK_O,
   input wire logic        OUTPUT_INVERT_SEL_O, RESOLUTION_SEL_O,
   input wire logic  [1:0] SEL_I,
   input wire logic  [7:0] WDATA_I, RDATA_O,
   input wire logic [15:0] DUTY_DATA_A_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!ARST_N_I);
   out_phase_a: assert property ($past(ARST_N_I) |-> PWM_O == ($past(PWM_RAW_I) ^ $past(OUTPUT_INVERT_SEL_O)))
      else $error("phase");
   ctrl_write_a: assert property (WR_I && SEL_I == 2'h3
      |=> {OUTPUT_INVERT_SEL_O, RESOLUTION_SEL_O} == $past(WDATA_I[1:0])) else $error("ctrl");
   full_step_a: assert property (!RESOLUTION_SEL_O [*3] |-> STEP_TICK_O) else $error("step");
   half_step_a: assert property (RESOLUTION_SEL_O [*3] ##0 STEP_TICK_O |=> !STEP_TICK_O) else $error("half");
   upper_hold_a: assert property (WR_I && UPPER_I && SEL_I == 2'h1 |=> $stable(DUTY_DATA_A_O)) else $error("hold");
   word_load_a: assert property (WR_I && UPPER_I && SEL_I != 2'h3 ##1 WR_I && !UPPER_I && SEL_I == 2'h1
      |=> DUTY_DATA_A_O == {$past(WDATA_I, 2), $past(WDATA_I)}) else $error("load");
   upper_read_a: assert property (RD_I && UPPER_I && SEL_I == 2'h1 |=> RDATA_O == $past(DUTY_DATA_A_O[15:8]))
      else $error("high");
   low_snap_a: assert property (RD_I && UPPER_I && SEL_I == 2'h1 ##1 RD_I && !UPPER_I && SEL_I != 2'h3
      |=> RDATA_O == $past(DUTY_DATA_A_O[7:0], 2)) else $error("low");
endmodule
bind pwm_dac_word_access_port pwm_dac_props i_props (.*);
`default_nettype wire

//--- tb/cpu_byte_master.sv
// bus master model making split byte accesses
`timescale 1ns/1ns
`default_nettype none
module cpu_byte_master (
   input  wire logic       CLK_SYS_I,
   input  wire logic [7:0] RDATA_O,
   output logic            WR_I, RD_I, UPPER_I,
   output logic      [1:0] SEL_I,
   output logic      [7:0] WDATA_I
);
   logic [7:0] got;
   initial {WR_I, RD_I, UPPER_I, SEL_I, WDATA_I} = '0;
   task automatic acc(input logic w, r, u, input logic [1:0] s, input logic [7:0] d);
      @(negedge CLK_SYS_I);
      got = RDATA_O;
      {WR_I, RD_I, UPPER_I, SEL_I} = {w, r, u, s};
      WDATA_I = w ? d : ~WDATA_I; // idle data line flips
   endtask
   // word moves only, upper byte first
   task automatic word(input logic w, input logic [1:0] s, input logic [15:0] d, output logic [15:0] v);
      acc(w, !w, 1, s, d[15:8]);
      acc(w, !w, 0, s, d[7:0]);
      v[15:8] = got;
      acc(0, 0, 0, s, 8'h00);
      v[7:0] = got;
   endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the pwm dac word access port
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %0t %h %h", $time, g, e); end end
module tb_top;
   import pwm_dac_pkg::*;
   logic CLK_SYS_I = 0, ARST_N_I = 0, COUNT_LOAD_I = 0, PWM_RAW_I = 1, WR_I, RD_I, UPPER_I, PWM_O, STEP_TICK_O;
   logic OUTPUT_INVERT_SEL_O, RESOLUTION_SEL_O, t;
   logic [1:0] SEL_I;
   logic [7:0] WDATA_I, RDATA_O;
   word_t PWM_STEP_COUNTER_O, DUTY_DATA_A_O, DUTY_DATA_B_O, v;
   int error_cnt, check_count;
   pwm_dac_word_access_port i_dut (.*);
   cpu_byte_master i_m (.*);
   initial forever #20 CLK_SYS_I = ~CLK_SYS_I;
   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_word;
      i_m.word(1, 2'h1, 16'hA55A, v);
      i_m.acc(1, 0, 1, 2'h2, 8'h3C);
      i_m.acc(0, 0, 0, 2'h2, 8'h00);
      `CHK(DUTY_DATA_B_O, 16'h0000)
      i_m.acc(1, 0, 0, 2'h2, 8'hC3);
      i_m.word(0, 2'h1, 16'h0000, v);
      `CHK(v, 16'hA55A)
      `CHK(DUTY_DATA_A_O, 16'hA55A)
      `CHK(DUTY_DATA_B_O, 16'h3CC3)
   endtask
   task automatic t_count;
      COUNT_LOAD_I = 1;
      @(negedge CLK_SYS_I);
      `CHK(PWM_STEP_COUNTER_O, 16'h0000)
      COUNT_LOAD_I = 0;
      i_m.word(1, 2'h0, 16'h12FE, v);
      i_m.word(0, 2'h0, 16'h0000, v);
      `CHK(v, 16'h12FF)
   endtask
   task automatic t_ctrl;
      i_m.acc(1, 0, 0, 2'h3, 8'h02);
      i_m.acc(0, 0, 0, 2'h3, 8'h00);
      @(negedge CLK_SYS_I);
      `CHK({OUTPUT_INVERT_SEL_O, PWM_O}, 2'h2)
      PWM_RAW_I = 0;
      @(negedge CLK_SYS_I);
      `CHK(PWM_O, 1'b1)
      PWM_RAW_I = 1;
      i_m.acc(1, 0, 0, 2'h3, 8'h01);
      repeat (2) i_m.acc(0, 0, 0, 2'h3, 8'h00);
      t = STEP_TICK_O;
      @(negedge CLK_SYS_I);
      `CHK({RESOLUTION_SEL_O, PWM_O, STEP_TICK_O}, {2'h3, ~t})
      i_m.acc(0, 1, 0, 2'h3, 8'h00);
      i_m.acc(0, 0, 0, 2'h3, 8'h00);
      `CHK(i_m.got, 8'h01)
   endtask
   initial
   begin
      repeat (20) @(negedge CLK_SYS_I);
      ARST_N_I = 1;
      `CHK({OUTPUT_INVERT_SEL_O, RESOLUTION_SEL_O}, 2'h0)
      t_word;
      t_count;
      t_ctrl;
      finish_test;
   end
   initial
   begin
      #20000;
      error_cnt++;
      finish_test;
   end
endmodule
`default_nettype wire
